// ==== design/pmcs_top.sv ====
// Operation
// - base register keeps address bits 23..15 in 15..7 and bit 11 in 3
// - base bits 6..4 and 2..0 read zero and ignore writes
// - reset loads base one 0x0200 and base two 0x0600
// - base two written all zero stretches region one to 0xffffff
// - alternate master wait is code plus three cycles, three to ten
// - setup wait is code plus one quarter instruction cycle
// - write strobe width is code plus one half cycle
// - read strobe width is code plus three quarters cycle
// - write data hold is code plus one quarter cycle
// - read data hold is code whole cycles, zero to three
//
// chip-select timing engine for a parallel master port
// assumes a classic wishbone master and synchronous external inputs
`timescale 1ns/100ps
`default_nettype none
`include "pmcs_map.svh"
module pmcs_top #(
  parameter int QDIV = 2
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // external link
  input  wire logic        external_acknowledge_input,
  output logic             cs_one_o,
  output logic             cs_two_o,
  output logic             strobe_o,
  output logic             write_o,
  output logic             data_oe_o,
  output logic      [23:0] addr_o
);
  import pmcs_pkg::*;

  logic [15:0] chip_select_one_base_reg;
  logic [15:0] chip_select_two_base_reg;
  logic [15:0] mode_reg [2];
  logic [23:0] acc_addr_reg;
  logic        acc_write_reg;
  logic        acc_alt_reg;
  logic        busy_reg;
  logic        timeout_reg;
  logic        start_reg;
  pmcs_state_e state_reg;
  logic [9:0]  qcnt_reg;
  logic [7:0]  tmo_reg;
  logic        tick;
  logic        wb_req;
  logic        sel_two;
  logic [15:0] cur_mode;
  logic [23:0] cs2_start;
  logic        cs2_off;
  logic [9:0]  setup_q;
  logic [9:0]  strb_q;
  logic [9:0]  hold_q;
  logic [9:0]  amw_q;
  logic [1:0]  acknowledge_mode_field;
  logic        link_on;

  pmcs_qdiv #(.QDIV(QDIV)) u_qdiv (
    .clock (clock),
    .rst_n (rst_n),
    .tick  (tick)
  );

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // region decode; base bit 11 and bits 23..15 form the start address
  assign cs2_start = {chip_select_two_base_reg[15:7], 3'h0,
                      chip_select_two_base_reg[3], 11'h000};
  assign cs2_off   = (chip_select_two_base_reg == 16'h0000);
  assign sel_two   = !cs2_off && (acc_addr_reg >= cs2_start);
  assign cur_mode  = sel_two ? mode_reg[1] : mode_reg[0];
  assign acknowledge_mode_field      = cur_mode[`PMCS_ACKNOWLEDGE_MODE_FIELD_HI:`PMCS_ACKNOWLEDGE_MODE_FIELD_LO];
  // zero read hold leaves the pins idle for its single clock
  assign link_on   = state_reg == PMCS_SETUP || state_reg == PMCS_STRB ||
                     (state_reg == PMCS_HOLD && hold_q != 10'h000);

  // all waits counted in quarter instruction cycles
  always_comb begin
    setup_q = 10'(cur_mode[`PMCS_SETUP_HI:`PMCS_SETUP_LO]) * 10'd4
            + 10'd1;
    if (acc_write_reg) begin
      strb_q = 10'(cur_mode[`PMCS_STRB_HI:`PMCS_STRB_LO]) * 10'd4
             + 10'd2;
      hold_q = 10'(cur_mode[`PMCS_HOLD_HI:`PMCS_HOLD_LO]) * 10'd4
             + 10'd1;
    end else begin
      strb_q = 10'(cur_mode[`PMCS_STRB_HI:`PMCS_STRB_LO]) * 10'd4
             + 10'd3;
      hold_q = 10'(cur_mode[`PMCS_HOLD_HI:`PMCS_HOLD_LO]) * 10'd4;
    end
    amw_q = (10'(cur_mode[`PMCS_AMW_HI:`PMCS_AMW_LO])
           + 10'd`PMCS_AMW_BASE) * 10'd4;
  end

  // base registers: only implemented bits take writes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      chip_select_one_base_reg <= `PMCS_RST_CS1_BASE;
      chip_select_two_base_reg <= `PMCS_RST_CS2_BASE;
    end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_sel_i[1]) begin
      if (wb_adr_i == `PMCS_OFS_CS1_BASE)
        chip_select_one_base_reg <= wb_dat_i[15:0]
                                  & `PMCS_BASE_MASK;
      if (wb_adr_i == `PMCS_OFS_CS2_BASE)
        chip_select_two_base_reg <= wb_dat_i[15:0]
                                  & `PMCS_BASE_MASK;
    end
  end

  // mode registers, one per select
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_mode
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          mode_reg[gi] <= `PMCS_RST_MODE;
        end else if (wb_req && wb_we_i && wb_sel_i[1:0] == 2'h3 &&
                     wb_adr_i == (`PMCS_OFS_CS1_MODE + 8'(gi * 4))) begin
          mode_reg[gi] <= wb_dat_i[15:0] & `PMCS_MODE_MASK;
        end
      end
    end
  endgenerate

  // access launch: address 23..0, bit 24 write, bit 25 alternate master
  // launches while busy are dropped; software polls busy first
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      acc_addr_reg  <= 24'h000000;
      acc_write_reg <= 1'b0;
      acc_alt_reg   <= 1'b0;
      start_reg     <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      if (wb_req && wb_we_i && wb_adr_i == `PMCS_OFS_ACCESS &&
          wb_sel_i == 4'hf && !busy_reg) begin
        acc_addr_reg  <= wb_dat_i[23:0];
        acc_write_reg <= wb_dat_i[24];
        acc_alt_reg   <= wb_dat_i[25];
        start_reg     <= 1'b1;
      end
    end
  end

  // timing sequencer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg   <= PMCS_IDLE;
      qcnt_reg    <= 10'h000;
      tmo_reg     <= 8'h00;
      busy_reg    <= 1'b0;
      timeout_reg <= 1'b0;
    end else begin
      case (state_reg)
        PMCS_IDLE: begin
          if (start_reg) begin
            busy_reg    <= 1'b1;
            timeout_reg <= 1'b0;
            qcnt_reg    <= 10'h000;
            state_reg   <= acc_alt_reg ? PMCS_AMW : PMCS_SETUP;
          end
        end
        PMCS_AMW: begin
          if (tick) qcnt_reg <= qcnt_reg + 10'h001;
          if (tick && qcnt_reg + 10'h001 >= amw_q) begin
            qcnt_reg  <= 10'h000;
            state_reg <= PMCS_SETUP;
          end
        end
        PMCS_SETUP: begin
          if (tick) qcnt_reg <= qcnt_reg + 10'h001;
          if (tick && qcnt_reg + 10'h001 >= setup_q) begin
            qcnt_reg  <= 10'h000;
            tmo_reg   <= 8'h00;
            state_reg <= PMCS_STRB;
          end
        end
        PMCS_STRB: begin
          if (tick) qcnt_reg <= qcnt_reg + 10'h001;
          if (tick && qcnt_reg[1:0] == 2'h3 && tmo_reg != 8'hff)
            tmo_reg <= tmo_reg + 8'h01;
          case (acknowledge_mode_field)
            PMCS_ACK_WAIT: begin
              if (external_acknowledge_input) begin
                qcnt_reg  <= 10'h000;
                state_reg <= PMCS_HOLD;
              end
            end
            PMCS_ACK_TMO: begin
              if (external_acknowledge_input) begin
                qcnt_reg  <= 10'h000;
                state_reg <= PMCS_HOLD;
              end else if (tick && qcnt_reg[1:0] == 2'h3 &&
                  ((cur_mode[5:2] == 4'h0 &&
                    tmo_reg == 8'(`PMCS_ACK_TIMEOUT - 1)) ||
                   (cur_mode[5:2] != 4'h0 &&
                    tmo_reg == 8'(cur_mode[5:2]) - 8'h01))) begin
                timeout_reg <= 1'b1;
                qcnt_reg    <= 10'h000;
                state_reg   <= PMCS_HOLD;
              end
            end
            default: begin
              // reserved ack code behaves as ack ignored
              if (tick && qcnt_reg + 10'h001 >= strb_q) begin
                qcnt_reg  <= 10'h000;
                state_reg <= PMCS_HOLD;
              end
            end
          endcase
        end
        PMCS_HOLD: begin
          if (tick) qcnt_reg <= qcnt_reg + 10'h001;
          if (hold_q == 10'h000 ||
              (tick && qcnt_reg + 10'h001 >= hold_q)) begin
            state_reg <= PMCS_DONE;
          end
        end
        PMCS_DONE: begin
          busy_reg  <= 1'b0;
          state_reg <= PMCS_IDLE;
        end
        default: state_reg <= PMCS_IDLE;
      endcase
    end
  end

  // registered pin outputs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cs_one_o  <= 1'b0;
      cs_two_o  <= 1'b0;
      strobe_o  <= 1'b0;
      write_o   <= 1'b0;
      data_oe_o <= 1'b0;
      addr_o    <= 24'h000000;
    end else begin
      cs_one_o  <= link_on && !sel_two;
      cs_two_o  <= link_on && sel_two;
      strobe_o  <= (state_reg == PMCS_STRB);
      write_o   <= acc_write_reg;
      data_oe_o <= acc_write_reg && (state_reg == PMCS_SETUP ||
                   state_reg == PMCS_STRB || state_reg == PMCS_HOLD);
      addr_o    <= acc_addr_reg;
    end
  end

  // wishbone answer one cycle after request; unmapped reads zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h00000000;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `PMCS_OFS_CS1_BASE: wb_dat_o <= {16'h0000, chip_select_one_base_reg};
          `PMCS_OFS_CS2_BASE: wb_dat_o <= {16'h0000, chip_select_two_base_reg};
          `PMCS_OFS_CS1_MODE: wb_dat_o <= {16'h0000, mode_reg[0]};
          `PMCS_OFS_CS2_MODE: wb_dat_o <= {16'h0000, mode_reg[1]};
          `PMCS_OFS_ACCESS:   wb_dat_o <= {6'h00, acc_alt_reg,
                                           acc_write_reg, acc_addr_reg};
          `PMCS_OFS_STATUS:   wb_dat_o <= {29'h0, cs2_off,
                                           timeout_reg, busy_reg};
          default:            wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // base reset values and read-zero holes
  base_rst_a: assert property (@(posedge clock)
    !rst_n |=> chip_select_one_base_reg == 16'h0200 &&
               chip_select_two_base_reg == 16'h0600)
    else $error("base reset value wrong");
  base_holes_a: assert property (@(posedge clock) disable iff (!rst_n)
    (chip_select_one_base_reg & 16'h0077) == 16'h0000 &&
    (chip_select_two_base_reg & 16'h0077) == 16'h0000)
    else $error("base hole bits set");
  base_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    wb_req && wb_we_i && wb_sel_i[1:0] == 2'h3 &&
    wb_adr_i == 8'h00 |=> chip_select_one_base_reg ==
    ($past(wb_dat_i[15:0]) & 16'hff88))
    else $error("base write not stored");
  cs_extend_a: assert property (@(posedge clock) disable iff (!rst_n)
    chip_select_two_base_reg == 16'h0000 && state_reg == PMCS_STRB |=>
    cs_one_o && !cs_two_o)
    else $error("select two used when zero");
  seq_order_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == PMCS_SETUP ##1 state_reg != PMCS_SETUP |->
    state_reg == PMCS_STRB)
    else $error("setup not followed by strobe");
  setup_len_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == PMCS_SETUP && tick && qcnt_reg + 10'h001 < setup_q |=>
    state_reg == PMCS_SETUP)
    else $error("setup ended early");
  strb_len_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == PMCS_STRB && acknowledge_mode_field == 2'h0 && tick &&
    qcnt_reg + 10'h001 >= strb_q |=> state_reg == PMCS_HOLD)
    else $error("strobe overran");
  ack_wait_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == PMCS_STRB && acknowledge_mode_field == 2'h2 && !external_acknowledge_input
    |=> state_reg == PMCS_STRB)
    else $error("strobe ended without ack");
  hold_end_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == PMCS_HOLD && hold_q == 10'h000 |=> state_reg == PMCS_DONE)
    else $error("zero hold not skipped");
  // alternate wait, ack-off strobe and nonzero data hold run to their full length; ack ends strobe
  amw_len_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == PMCS_AMW && tick && qcnt_reg + 10'h001 < amw_q |=>
    state_reg == PMCS_AMW)
    else $error("alternate wait ended early");
  strb_min_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == PMCS_STRB && acknowledge_mode_field == 2'h0 && tick &&
    qcnt_reg + 10'h001 < strb_q |=> state_reg == PMCS_STRB)
    else $error("strobe ended early");
  hold_len_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == PMCS_HOLD && hold_q != 10'h000 && tick &&
    qcnt_reg + 10'h001 < hold_q |=> state_reg == PMCS_HOLD)
    else $error("data hold ended early");
  ack_end_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == PMCS_STRB && acknowledge_mode_field == 2'h1 && external_acknowledge_input
    |=> state_reg == PMCS_HOLD)
    else $error("ack did not end strobe");
  zero_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == PMCS_HOLD && hold_q == 10'h000 |=>
    !cs_one_o && !cs_two_o)
    else $error("select held in zero hold");
endmodule : pmcs_top
`default_nettype wire

// ==== design/pmcs_map.svh ====
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit classic wishbone slave, one register per aligned word
`ifndef PMCS_MAP_SVH
`define PMCS_MAP_SVH
`define PMCS_OFS_CS1_BASE   8'h00
`define PMCS_OFS_CS2_BASE   8'h04
`define PMCS_OFS_CS1_MODE   8'h08
`define PMCS_OFS_CS2_MODE   8'h0c
`define PMCS_OFS_ACCESS     8'h10
`define PMCS_OFS_STATUS     8'h14
`define PMCS_RST_CS1_BASE   16'h0200
`define PMCS_RST_CS2_BASE   16'h0600
`define PMCS_RST_MODE       16'h0000
`define PMCS_BASE_MASK      16'hff88
`define PMCS_MODE_MASK      16'hf8ff
`define PMCS_ACKNOWLEDGE_MODE_FIELD_HI        15
`define PMCS_ACKNOWLEDGE_MODE_FIELD_LO        14
`define PMCS_AMW_HI         13
`define PMCS_AMW_LO         11
`define PMCS_SETUP_HI       7
`define PMCS_SETUP_LO       6
`define PMCS_STRB_HI        5
`define PMCS_STRB_LO        2
`define PMCS_HOLD_HI        1
`define PMCS_HOLD_LO        0
`define PMCS_QUARTERS       4
`define PMCS_ACK_TIMEOUT    255
`define PMCS_AMW_BASE       3
`define PMCS_TOP_ADDR       24'hffffff
`endif

// ==== design/pmcs_pkg.sv ====
// types shared by the chip-select timing block
// assumes nothing beyond the map header
package pmcs_pkg;
  typedef enum logic [1:0] {
    PMCS_ACK_OFF  = 2'h0,
    PMCS_ACK_TMO  = 2'h1,
    PMCS_ACK_WAIT = 2'h2,
    PMCS_ACK_RSVD = 2'h3
  } pmcs_acknowledge_mode_field_e;
  typedef enum logic [5:0] {
    PMCS_IDLE  = 6'h01,
    PMCS_SETUP = 6'h02,
    PMCS_STRB  = 6'h04,
    PMCS_HOLD  = 6'h08,
    PMCS_AMW   = 6'h10,
    PMCS_DONE  = 6'h20
  } pmcs_state_e;
endpackage : pmcs_pkg

// ==== design/pmcs_qdiv.sv ====
// quarter-cycle enable divider
// assumes one system clock; emits one pulse every QDIV clocks
`timescale 1ns/100ps
`default_nettype none
module pmcs_qdiv #(
  parameter int QDIV = 2
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // quarter-cycle tick
  output logic      tick
);
  logic [7:0] cnt_reg;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_reg <= 8'h00;
      tick    <= 1'b0;
    end else if (cnt_reg == 8'(QDIV - 1)) begin
      cnt_reg <= 8'h00;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      tick    <= 1'b0;
    end
  end
endmodule : pmcs_qdiv
`default_nettype wire

// ==== dv/pmcs_ext_dev.sv ====
// external part model: answers the strobe with an acknowledge after a delay
// assumes strobe comes from the block's registered pin, one clock domain
`timescale 1ns/100ps
`default_nettype none
module pmcs_ext_dev (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // link
  input  wire logic       strobe,
  input  wire logic [7:0] ack_delay,
  output logic            ack
);
  logic [7:0] cnt_reg;
  // zero delay means the part never answers, to force a time-out
  always_ff @(posedge clock) begin
    if (!rst_n || !strobe) begin
      cnt_reg <= 8'h00;
      ack     <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      ack     <= (ack_delay != 8'h00) && (cnt_reg + 8'h01 >= ack_delay);
    end
  end
endmodule : pmcs_ext_dev
`default_nettype wire

// ==== dv/tb.sv ====
// register and link-timing tests for the chip-select timing block
// assumes pmcs_top with QDIV=1, so one quarter cycle is one clock
`timescale 1ns/100ps
`default_nettype none
`include "pmcs_map.svh"
module tb;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic        wb_ack_o, ext_ack, cs_one_o, cs_two_o, strobe_o;
  logic        write_o, data_oe_o, seen, two, pw, alt = 1'b0;
  logic [23:0] addr_o, pa;
  logic [3:0]  sel = 4'hf;
  logic [7:0]  ack_delay = 8'h00;
  int          errors = 0, total_checks = 0, cycles = 0, su, sw, hd;
  int          oe, t0, tcs;
  always #4 clock = ~clock;
  pmcs_top #(.QDIV(1)) u_dut (.clock(clock), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(sel), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .external_acknowledge_input(ext_ack), .cs_one_o(cs_one_o),
    .cs_two_o(cs_two_o), .strobe_o(strobe_o), .write_o(write_o),
    .data_oe_o(data_oe_o), .addr_o(addr_o));
  pmcs_ext_dev u_ext (.clock(clock), .rst_n(rst_n), .strobe(strobe_o),
    .ack_delay(ack_delay), .ack(ext_ack));
  // phase counters; the pins all lag by one clock so differences hold
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (data_oe_o) oe <= oe + 1;
    if (strobe_o) begin
      pa <= addr_o;
      pw <= write_o;
    end
    if (cs_one_o || cs_two_o) begin
      if (strobe_o) begin
        sw   <= sw + 1;
        seen <= 1'b1;
      end else if (seen) hd <= hd + 1;
      else begin
        if (su == 0) tcs <= cycles;
        su <= su + 1;
      end
      if (cs_two_o) two <= 1'b1;
    end
    if (cycles > 20000) begin
      errors = errors + 1;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  // launch one access and wait until the busy flag clears
  task automatic go(input logic wr, input logic [23:0] a);
    wb(1'b1, `PMCS_OFS_ACCESS, {6'h0, alt, wr, a});
    t0 = cycles;
    su = 0; sw = 0; hd = 0; oe = 0; seen = 1'b0; two = 1'b0;
    do wb(1'b0, `PMCS_OFS_STATUS, 32'h0); while (rd[0] === 1'b1);
  endtask : go
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    wb(1'b0, `PMCS_OFS_CS1_BASE, 0); chk(rd, 32'h0200);
    wb(1'b0, `PMCS_OFS_CS2_BASE, 0); chk(rd, 32'h0600);
    wb(1'b0, `PMCS_OFS_CS1_MODE, 0); chk(rd, 32'h0000);
    wb(1'b1, `PMCS_OFS_CS1_BASE, 32'hffff);
    wb(1'b0, `PMCS_OFS_CS1_BASE, 0); chk(rd, 32'hff88);
    wb(1'b1, `PMCS_OFS_CS1_MODE, 32'hffff);
    wb(1'b0, `PMCS_OFS_CS1_MODE, 0); chk(rd, 32'hf8ff);
    wb(1'b0, 8'h40, 0); chk(rd, 32'h0);
    wb(1'b1, `PMCS_OFS_CS1_BASE, 32'h0208);
    wb(1'b0, `PMCS_OFS_CS1_BASE, 0); chk(rd, 32'h0208);
    sel <= 4'h1;
    wb(1'b1, `PMCS_OFS_CS1_BASE, 32'h1234);
    sel <= 4'hf;
    wb(1'b0, `PMCS_OFS_CS1_BASE, 0); chk(rd, 32'h0208);
    $display("registers done");
    // every set-up and hold code, strobe codes 0, 5, 10, 15
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, `PMCS_OFS_CS1_MODE, {24'h0, i[1:0], 4'(i * 5), i[1:0]});
      go(1'b1, 24'h030000);
      chk(su, i * 4 + 1);
      chk(sw, i * 20 + 2);
      chk(hd, i * 4 + 1);
      chk(two, 0);
      chk(oe, i * 28 + 4);
      chk({pw, pa}, {1'b1, 24'h030000});
      go(1'b0, 24'h030000);
      chk(su, i * 4 + 1);
      chk(sw, i * 20 + 3);
      chk(hd, i * 4);
      chk(oe, 0);
      chk({pw, pa}, {1'b0, 24'h030000});
    end
    $display("timing done");
    wb(1'b1, `PMCS_OFS_CS2_MODE, 32'h0004);
    go(1'b1, 24'h070000);
    chk(two, 1);
    chk(sw, 6);
    wb(1'b1, `PMCS_OFS_CS2_BASE, 32'h0);
    wb(1'b0, `PMCS_OFS_STATUS, 0); chk(rd[2], 1);
    go(1'b0, 24'hfff000);
    chk(two, 0);
    chk(su, 3 * 4 + 1);
    $display("region done");
    // acknowledge waits: slow part, a part that never answers, one that answers in time; then alternate master wait
    ack_delay <= 8'd40;
    wb(1'b1, `PMCS_OFS_CS1_MODE, 32'h8000);
    go(1'b0, 24'h030000);
    chk(sw >= 40, 1);
    ack_delay <= 8'd0;
    wb(1'b1, `PMCS_OFS_CS1_MODE, 32'h4000);
    go(1'b0, 24'h030000);
    wb(1'b0, `PMCS_OFS_STATUS, 0); chk(rd[1], 1);
    chk(sw >= 255 * 4, 1);
    wb(1'b1, `PMCS_OFS_CS1_MODE, 32'h4008);
    go(1'b0, 24'h030000);
    chk(sw, 2 * 4);
    ack_delay <= 8'd5;
    wb(1'b1, `PMCS_OFS_CS1_MODE, 32'h4000);
    go(1'b0, 24'h030000);
    wb(1'b0, `PMCS_OFS_STATUS, 0); chk(rd[1], 0);
    chk(sw, 5 + 2);
    alt = 1'b1;
    wb(1'b1, `PMCS_OFS_CS1_MODE, 32'h3800);
    go(1'b0, 24'h030000);
    chk(sw, 3);
    chk(tcs - t0, 2 + 10 * 4);
    $display("acknowledge done");
    test_done();
  end
endmodule : tb
`default_nettype wire
